// ==== verilog/bdp_status.sv ====
// parity status bits, enables, interrupt and register port of the bridge
`default_nettype none

module bdp_status
    import bdp_pkg::*;
#(
    parameter int COUNT_W = CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire bdp_evt_t evt,
    input wire logic primary_parity_err_pin_n,
    input wire logic secondary_parity_err_pin_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic [NUM_BITS-1:0] parity_status,
    output logic pri_per_en_out,
    output logic sec_per_en_out,
    output logic irq
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [NUM_BITS-1:0] mask;
    logic [LAST_W-1:0] last_evt;
    logic last_valid;
    logic [NUM_BITS-1:0] flags;
    logic [COUNT_W-1:0] cnt [NUM_BITS];

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic wr_last;

    assign wr_ctrl = reg_wr && hit(reg_addr, OFS_CTRL);
    assign wr_status = reg_wr && hit(reg_addr, OFS_STATUS);
    assign wr_mask = reg_wr && hit(reg_addr, OFS_MASK);
    assign wr_last = reg_wr && hit(reg_addr, OFS_LAST);

    // ------------------------------------------------------------
    // enables and pins
    // ------------------------------------------------------------
    bdp_enables_t en;
    logic pri_pin_low;
    logic sec_pin_low;

    // one driver for the whole struct keeps strict elaborators happy
    assign en = {ctrl[CTRL_PRI_PER], ctrl[CTRL_SEC_PER]};
    // pins are active low and sampled in the event cycle
    assign pri_pin_low = !primary_parity_err_pin_n;
    assign sec_pin_low = !secondary_parity_err_pin_n;

    // ------------------------------------------------------------
    // event classification
    // ------------------------------------------------------------
    logic [NUM_BITS-1:0] set;
    logic [NUM_BITS-1:0] clr;

    bdp_classify u_classify (
        .evt(evt),
        .en(en),
        .pri_pin_low(pri_pin_low),
        .sec_pin_low(sec_pin_low),
        .set(set)
    );

    assign clr = wr_status ? reg_wdata[NUM_BITS-1:0] : '0;

    // ------------------------------------------------------------
    // sticky status
    // ------------------------------------------------------------
    bdp_sticky #(
        .WIDTH(NUM_BITS)
    ) u_sticky (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(set),
        .clr(clr),
        .flags(flags)
    );

    // ------------------------------------------------------------
    // control and mask
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] next_ctrl;
    logic [NUM_BITS-1:0] next_mask;

    assign next_ctrl = wr_ctrl ? reg_wdata[CTRL_W-1:0] : ctrl;
    assign next_mask = wr_mask ? reg_wdata[NUM_BITS-1:0] : mask;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
            mask <= MASK_RST;
        end else begin
            ctrl <= next_ctrl;
            mask <= next_mask;
        end
    end

    // ------------------------------------------------------------
    // per-bit event counters
    // ------------------------------------------------------------
    // saturate rather than wrap so a busy bus never reads as quiet
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BITS; gi++) begin : g_cnt
            logic [COUNT_W-1:0] next_cnt;
            logic sat;

            assign sat = (cnt[gi] == COUNT_W'(CNT_MAX));
            assign next_cnt = clr[gi] ? COUNT_W'(set[gi])
                            : (set[gi] && !sat) ? cnt[gi] + COUNT_W'(1) : cnt[gi];

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cnt[gi] <= COUNT_W'(CNT_RST);
                end else begin
                    cnt[gi] <= next_cnt;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // last event capture
    // ------------------------------------------------------------
    logic any_set;
    logic capture;
    logic [LAST_W-1:0] evt_word;
    logic [LAST_W-1:0] next_last;
    logic next_last_valid;

    assign any_set = |set;
    // hold-first mode keeps the oldest error for diagnosis
    assign capture = any_set && !(ctrl[CTRL_HOLD_FIRST] && last_valid);
    assign evt_word = {1'b1, sec_pin_low, pri_pin_low, evt.detected,
                       evt.err_on_sec, evt.upstream, evt.xtype};
    assign next_last = capture ? evt_word : (wr_last ? '0 : last_evt);
    assign next_last_valid = capture || (last_valid && !wr_last);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_evt <= '0;
            last_valid <= 1'b0;
        end else begin
            last_evt <= next_last;
            last_valid <= next_last_valid;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;

    assign rd_mux =
        hit(reg_addr, OFS_CTRL) ? DATA_W'(ctrl) :
        hit(reg_addr, OFS_STATUS) ? DATA_W'(flags) :
        hit(reg_addr, OFS_MASK) ? DATA_W'(mask) :
        hit(reg_addr, OFS_LAST) ? DATA_W'(last_evt) :
        hit(reg_addr, OFS_CNT0) ? DATA_W'(cnt[0]) :
        hit(reg_addr, OFS_CNT1) ? DATA_W'(cnt[1]) :
        hit(reg_addr, OFS_CNT2) ? DATA_W'(cnt[2]) :
        hit(reg_addr, OFS_CNT3) ? DATA_W'(cnt[3]) : RDATA_ZERO;

    logic [DATA_W-1:0] next_rdata;
    assign next_rdata = reg_rd ? rd_mux : RDATA_ZERO;

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic next_irq;
    logic [NUM_BITS-1:0] next_flags_view;

    assign next_flags_view = set | (flags & ~clr);
    // irq is computed from the next status so both change at the same edge
    assign next_irq = |(next_flags_view & mask);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= RDATA_ZERO;
            irq <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            irq <= next_irq;
        end
    end

    assign parity_status = flags;
    assign pri_per_en_out = ctrl[CTRL_PRI_PER];
    assign sec_per_en_out = ctrl[CTRL_SEC_PER];

endmodule : bdp_status

`default_nettype wire

// ==== verilog/bdp_pkg.sv ====
// shared constants and types for the bridge data parity status block
`default_nettype none

package bdp_pkg;

    // ------------------------------------------------------------
    // register bus shape
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_BITS = 4;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LAST = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CNT0 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CNT1 = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CNT2 = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CNT3 = 8'h1C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_PRI_PER = 0;
    localparam int CTRL_SEC_PER = 1;
    localparam int CTRL_HOLD_FIRST = 2;
    localparam int CTRL_W = 3;

    localparam int ST_PRI_DPE = 0;
    localparam int ST_SEC_DPE = 1;
    localparam int ST_PRI_MDP = 2;
    localparam int ST_SEC_MDP = 3;

    localparam int LAST_W = 8;

    // ------------------------------------------------------------
    // reset values and the counter saturation limit
    // ------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [NUM_BITS-1:0] MASK_RST = 4'h0;
    localparam logic [NUM_BITS-1:0] STATUS_RST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // transaction description
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BDP_READ = 2'h0,
        BDP_POSTED = 2'h1,
        BDP_DELAYED = 2'h2
    } bdp_xtype_t;

    typedef struct packed {
        logic valid;
        bdp_xtype_t xtype;
        logic upstream;
        logic err_on_sec;
        logic is_master;
        logic detected;
    } bdp_evt_t;

    typedef struct packed {
        logic pri_per_en;
        logic sec_per_en;
    } bdp_enables_t;

endpackage : bdp_pkg

`default_nettype wire

// ==== verilog/bdp_sticky.sv ====
// write-one-to-clear sticky bits where a hardware set beats a clear
`default_nettype none

module bdp_sticky
    import bdp_pkg::*;
#(
    parameter int WIDTH = NUM_BITS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] next_flags;

    // set has priority so an event in the clearing cycle survives
    assign next_flags = set | (flags & ~clr);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

endmodule : bdp_sticky

`default_nettype wire

// ==== verilog/bdp_classify.sv ====
// decides which parity status bits one reported event sets
`default_nettype none

module bdp_classify
    import bdp_pkg::*;
(
    input wire bdp_evt_t evt,
    input wire bdp_enables_t en,
    input wire logic pri_pin_low,
    input wire logic sec_pin_low,
    output logic [NUM_BITS-1:0] set
);

    logic is_read;
    logic is_write;
    logic on_pri;
    logic on_sec;
    logic pri_target_side;
    logic sec_target_side;
    logic pri_master_err;
    logic sec_master_err;

    assign is_read = (evt.xtype == BDP_READ);
    assign is_write = (evt.xtype == BDP_POSTED) || (evt.xtype == BDP_DELAYED);
    assign on_pri = evt.valid && !evt.err_on_sec;
    assign on_sec = evt.valid && evt.err_on_sec;

    // primary receives data on upstream reads and downstream writes
    assign pri_target_side = (is_read && evt.upstream) || (is_write && !evt.upstream);
    assign sec_target_side = (is_read && !evt.upstream) || (is_write && evt.upstream);

    // own detection or the far target's error pin, only as master
    assign pri_master_err = evt.detected || pri_pin_low;
    assign sec_master_err = evt.detected || sec_pin_low;

    // enables do not gate the detected bits
    assign set[ST_PRI_DPE] = on_pri && evt.detected && pri_target_side;
    assign set[ST_SEC_DPE] = on_sec && evt.detected && sec_target_side;
    assign set[ST_PRI_MDP] = on_pri && evt.is_master && evt.upstream && (is_read || is_write)
                             && en.pri_per_en && pri_master_err;
    assign set[ST_SEC_MDP] = on_sec && evt.is_master && !evt.upstream && (is_read || is_write)
                             && en.sec_per_en && sec_master_err;

endmodule : bdp_classify

`default_nettype wire

// ==== tb/bdp_status_assertions.sv ====
// checker for the parity status block ports
`default_nettype none
module bdp_status_assertions
    import bdp_pkg::*;
#(
    parameter int COUNT_W = CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire bdp_evt_t evt,
    input wire logic primary_parity_err_pin_n,
    input wire logic secondary_parity_err_pin_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [NUM_BITS-1:0] parity_status,
    input wire logic pri_per_en_out,
    input wire logic sec_per_en_out,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic rd = evt.valid && evt.xtype == BDP_READ;
    wire logic wr = evt.valid && (evt.xtype == BDP_POSTED || evt.xtype == BDP_DELAYED);
    wire logic up = evt.upstream;
    wire logic sb = evt.err_on_sec;
    wire logic pd_c = !sb && evt.detected && (rd && up || wr && !up);
    wire logic sd_c = sb && evt.detected && (rd && !up || wr && up);
    wire logic pm_c = (rd || wr) && !sb && up && evt.is_master && pri_per_en_out;
    wire logic sm_c = (rd || wr) && sb && !up && evt.is_master && sec_per_en_out;
    wire logic [NUM_BITS-1:0] clr_req = (reg_wr && reg_addr == OFS_STATUS) ?
        reg_wdata[NUM_BITS-1:0] : '0;
    sequence pm_hit_s;
        pm_c && (evt.detected || !primary_parity_err_pin_n);
    endsequence
    sequence sm_hit_s;
        sm_c && (evt.detected || !secondary_parity_err_pin_n);
    endsequence
    sequence clr_all_s;
        reg_wr && reg_addr == OFS_STATUS && reg_wdata[3:0] == 4'hF && !evt.valid;
    endsequence
    pri_dpe_set_a: assert property (pd_c |=> parity_status[ST_PRI_DPE])
        else $error("primary detected bit not set");
    pri_dpe_only_a: assert property ($rose(parity_status[ST_PRI_DPE]) |-> $past(pd_c))
        else $error("primary detected bit set without cause");
    sec_dpe_set_a: assert property (sd_c |=> parity_status[ST_SEC_DPE])
        else $error("secondary detected bit not set");
    sec_dpe_only_a: assert property ($rose(parity_status[ST_SEC_DPE]) |-> $past(sd_c))
        else $error("secondary detected bit set without cause");
    pri_mdp_set_a: assert property (pm_hit_s |=> parity_status[ST_PRI_MDP])
        else $error("primary master parity bit not set");
    pri_mdp_only_a: assert property ($rose(parity_status[ST_PRI_MDP]) |-> $past(pm_c))
        else $error("primary master parity bit set without cause");
    sec_mdp_set_a: assert property (sm_hit_s |=> parity_status[ST_SEC_MDP])
        else $error("secondary master parity bit not set");
    sec_mdp_only_a: assert property ($rose(parity_status[ST_SEC_MDP]) |-> $past(sm_c))
        else $error("secondary master parity bit set without cause");
    sticky_bits_a: assert property (1'b1 |=>
        (($past(parity_status) & ~$past(clr_req)) & ~parity_status) == 4'h0)
        else $error("status bit dropped without a clear");
    clear_all_a: assert property (clr_all_s |=> parity_status == 4'h0)
        else $error("status bits not cleared");
    irq_src_a: assert property (irq |-> parity_status != 4'h0)
        else $error("interrupt without status");
endmodule // bdp_status_assertions

bind bdp_status bdp_status_assertions #(.COUNT_W(COUNT_W)) bdp_status_assertions_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .evt(evt),
    .primary_parity_err_pin_n(primary_parity_err_pin_n),
    .secondary_parity_err_pin_n(secondary_parity_err_pin_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .parity_status(parity_status), .pri_per_en_out(pri_per_en_out),
    .sec_per_en_out(sec_per_en_out), .irq(irq));
`default_nettype wire

// ==== tb/bdp_agent.sv ====
// behavioural bus agents reporting parity events
`default_nettype none
module bdp_agent
    import bdp_pkg::*;
(
    input wire logic clk_sys,
    output bdp_evt_t evt,
    output logic pri_pin_n,
    output logic sec_pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        evt = '0;
        pri_pin_n = 1'b1;
        sec_pin_n = 1'b1;
    end
    // pins are pulled up, so they read high once the target lets go
    task automatic send(input bdp_evt_t e, input logic pin_low, input int idle);
        repeat (idle) @(posedge clk_sys);
        @(posedge clk_sys);
        evt <= e;
        pri_pin_n <= !(pin_low && !e.err_on_sec);
        sec_pin_n <= !(pin_low && e.err_on_sec);
        @(posedge clk_sys);
        evt <= '0;
        pri_pin_n <= 1'b1;
        sec_pin_n <= 1'b1;
        #1;
    endtask
endmodule // bdp_agent
`default_nettype wire

// ==== tb/bdp_status_tb.sv ====
// self-checking bench for the parity status block
`default_nettype none
module bdp_status_tb
    import bdp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys;
    logic rst_n;
    bdp_evt_t evt;
    logic ppin_n;
    logic spin_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rd;
    logic reg_wr;
    logic reg_rd;
    logic pri_en;
    logic sec_en;
    logic irq;
    logic [NUM_BITS-1:0] status;
    int err_total;
    int samples_checked;

    bdp_agent bdp_agent_i (.clk_sys(clk_sys), .evt(evt), .pri_pin_n(ppin_n), .sec_pin_n(spin_n));
    bdp_status bdp_status_i (.clk_sys(clk_sys), .rst_n(rst_n), .evt(evt),
        .primary_parity_err_pin_n(ppin_n), .secondary_parity_err_pin_n(spin_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .parity_status(status), .pri_per_en_out(pri_en),
        .sec_per_en_out(sec_en), .irq(irq));

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // irq is registered, so allow one more edge after the cause
    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [NUM_BITS-1:0] exp_bits(bdp_evt_t e, logic pe, logic se, logic p);
        logic r;
        logic w;
        r = e.xtype == BDP_READ;
        w = e.xtype == BDP_POSTED || e.xtype == BDP_DELAYED;
        exp_bits[ST_PRI_DPE] = !e.err_on_sec && e.detected && (r && e.upstream || w && !e.upstream);
        exp_bits[ST_SEC_DPE] = e.err_on_sec && e.detected && (r && !e.upstream || w && e.upstream);
        exp_bits[ST_PRI_MDP] = (r || w) && !e.err_on_sec && e.upstream && e.is_master && pe &&
            (e.detected || p);
        exp_bits[ST_SEC_MDP] = (r || w) && e.err_on_sec && !e.upstream && e.is_master && se &&
            (e.detected || p);
    endfunction

    task automatic reset_values();
        check(DATA_W'({pri_en, sec_en, irq, status}), 32'h0);
        reg_read(OFS_CTRL, rd);
        check(rd, DATA_W'(CTRL_RST));
        reg_read(OFS_MASK, rd);
        check(rd, DATA_W'(MASK_RST));
        reg_write(8'hF0, 32'hFFFF_FFFF);
        reg_read(8'hF0, rd);
        check(rd, 32'h0);
        reg_write(OFS_CTRL, 32'h0000_0003);
        settle();
        check(DATA_W'({pri_en, sec_en}), 32'h3);
    endtask
    task automatic sweep_table();
        bdp_evt_t e;
        int r;
        logic p;
        for (int i = 0; i < 288; i++) begin
            r = i / 3;
            e = '0;
            e.valid = 1'b1;
            e.xtype = bdp_xtype_t'(i % 3);
            e.upstream = r[0];
            e.err_on_sec = r[1];
            e.is_master = r[2];
            e.detected = (r / 32) != 1;
            p = (r / 32) != 0;
            reg_write(OFS_STATUS, 32'h0000_000F);
            reg_write(OFS_CTRL, {30'h0, r[4], r[3]});
            bdp_agent_i.send(e, p, i % 4);
            check(DATA_W'(status), DATA_W'(exp_bits(e, r[3], r[4], p)));
        end
    endtask
    task automatic sticky_irq();
        bdp_evt_t e;
        e = '0;
        e.valid = 1'b1;
        e.xtype = bdp_xtype_t'(2'h3);
        e.upstream = 1'b1;
        e.is_master = 1'b1;
        e.detected = 1'b1;
        reg_write(OFS_CTRL, 32'h0000_0003);
        reg_write(OFS_STATUS, 32'h0000_000F);
        bdp_agent_i.send(e, 1'b1, 0);
        check(DATA_W'(status), 32'h0);
        e.xtype = BDP_READ;
        bdp_agent_i.send(e, 1'b0, 0);
        reg_write(OFS_MASK, 32'h0000_0001);
        settle();
        check(DATA_W'(irq), 32'h1);
        reg_write(OFS_STATUS, 32'h0000_000A);
        reg_read(OFS_STATUS, rd);
        check(rd, 32'h5);
        reg_read(OFS_CNT0, rd);
        check(rd, 32'h1);
        reg_read(OFS_LAST, rd);
        check(rd, 32'h94);
        reg_write(OFS_MASK, 32'h0);
        settle();
        check(DATA_W'(irq), 32'h0);
        reg_write(OFS_MASK, 32'h0000_0001);
        reg_write(OFS_STATUS, 32'h0000_0001);
        settle();
        check(DATA_W'({irq, status}), 32'h4);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_total = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        reset_values();
        sweep_table();
        sticky_irq();
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end
endmodule // bdp_status_tb
`default_nettype wire
